// >>> rtl/cst_card_timing.sv
// card slot command timing engine with wishbone register file
// assumes card_wait_n and io16 come from pins, asynchronous to clock_i
`timescale 1ns/1ps
module cst_card_timing (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic             clk_en_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // access request
  input  wire cst_pkg::cst_acc_t acc_i,
  output logic                  acc_busy_o,
  output logic                  acc_done_o,
  // card pins
  input  wire logic             card_wait_n_i,
  input  wire logic             io_width16_indicate_n_i,
  output logic                  cmd_strobe_n_o,
  output logic                  io_width16_o,
  output logic                  card_present_flag_o
);
  import cst_pkg::*;

  cst_state_s_t s_r;
  cst_state_s_t s_nxt;
  logic [31:0]  tim;
  logic [CST_CNT_W-1:0] setv;
  logic [CST_CNT_W-1:0] holdv;
  logic [CST_CNT_W-1:0] code;
  logic         wait_seen;
  logic         wb_req;
  logic [31:0]  wmask;

  // ------------------------------------------------------------
  // field selection
  // ------------------------------------------------------------
  always_comb begin
    unique case (acc_i.space)
      CST_SP_ATTR: tim = s_r.tim_attr_r;
      CST_SP_IO:   tim = s_r.tim_io_r;
      default:     tim = s_r.tim_common_r;
    endcase
    setv  = CST_CNT_W'(tim[CST_SET_LSB +: CST_SET_W]);
    holdv = CST_CNT_W'(tim[CST_HOLD_LSB +: CST_HOLD_W]);
    code  = CST_CNT_W'(tim[CST_ASST_LSB +: CST_ASST_W]);
    if (setv == '0) setv = CST_ONE;
    if (holdv == '0) holdv = CST_ONE;
    // wait released: active-low pin high means card ready
    wait_seen = s_r.present_r ? s_r.wait_sy_r[1] : 1'b1;
    wb_req = wb_cyc_i & wb_stb_i & ~s_r.ack_r;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // two-flop synchronisers
    s_nxt.wait_sy_r = {s_r.wait_sy_r[0], card_wait_n_i};
    s_nxt.io16_sy_r = {s_r.io16_sy_r[0], io_width16_indicate_n_i};
    s_nxt.io16_r = s_r.present_r & ~s_r.io16_sy_r[1];
    s_nxt.ack_r = wb_req;
    s_nxt.done_r = 1'b0;
    if (wb_req) begin
      unique case (wb_adr_i)
        CST_OFS_COMMON:   s_nxt.dat_r = s_r.tim_common_r;
        CST_OFS_ATTR:     s_nxt.dat_r = s_r.tim_attr_r;
        CST_OFS_IO:       s_nxt.dat_r = s_r.tim_io_r;
        CST_OFS_PRESENCE: s_nxt.dat_r = {30'h0, s_r.present_r, 1'b0};
        default:          s_nxt.dat_r = 32'h0000_0000;
      endcase
      if (wb_we_i) begin
        unique case (wb_adr_i)
          CST_OFS_COMMON: s_nxt.tim_common_r = (s_r.tim_common_r & ~wmask)
              | (wb_dat_i & wmask & CST_TIMING_MASK);
          CST_OFS_ATTR: s_nxt.tim_attr_r = (s_r.tim_attr_r & ~wmask)
              | (wb_dat_i & wmask & CST_TIMING_MASK);
          CST_OFS_IO: s_nxt.tim_io_r = (s_r.tim_io_r & ~wmask)
              | (wb_dat_i & wmask & CST_TIMING_MASK);
          CST_OFS_PRESENCE: if (wb_sel_i[0])
              s_nxt.present_r = wb_dat_i[CST_PRES_BIT];
          default: ;
        endcase
      end
    end
    // command strobe sequencer
    unique case (s_r.st_r)
      CST_IDLE: begin
        if (acc_i.req) begin
          s_nxt.st_r   = CST_SETUP;
          s_nxt.busy_r = 1'b1;
          s_nxt.cnt_r  = setv;
          s_nxt.hold_r = holdv;
          s_nxt.min_r  = CST_CNT_W'(3) * code + CST_CNT_W'(3);
          s_nxt.total_r = '0;
        end
      end
      CST_SETUP: begin
        if (s_r.cnt_r == CST_ONE) begin
          s_nxt.st_r     = CST_WAITCHK;
          s_nxt.strobe_n_r = 1'b0;
          s_nxt.cnt_r    = code + CST_ONE;
          s_nxt.total_r  = CST_ONE;
        end else s_nxt.cnt_r = s_r.cnt_r - CST_ONE;
      end
      CST_WAITCHK: begin
        s_nxt.total_r = s_r.total_r + CST_ONE;
        if (s_r.cnt_r > CST_ONE) s_nxt.cnt_r = s_r.cnt_r - CST_ONE;
        else if (wait_seen) begin
          s_nxt.st_r  = CST_HOLD;
          s_nxt.cnt_r = (code << 1) + CST_TWO;
        end
      end
      CST_HOLD: begin
        s_nxt.total_r = s_r.total_r + CST_ONE;
        if (s_r.cnt_r > CST_ONE) s_nxt.cnt_r = s_r.cnt_r - CST_ONE;
        else if (s_r.total_r >= s_r.min_r) begin
          s_nxt.st_r     = CST_RECOV;
          s_nxt.strobe_n_r = 1'b1;
          s_nxt.cnt_r    = s_r.hold_r;
        end
      end
      CST_RECOV: begin
        if (s_r.cnt_r == CST_ONE) begin
          s_nxt.st_r   = CST_IDLE;
          s_nxt.busy_r = 1'b0;
          s_nxt.done_r = 1'b1;
        end else s_nxt.cnt_r = s_r.cnt_r - CST_ONE;
      end
      // unused state codes fall back to idle
      default: begin
        s_nxt.st_r       = CST_IDLE;
        s_nxt.busy_r     = 1'b0;
        s_nxt.strobe_n_r = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r              <= '0;
      s_r.tim_common_r <= CST_TIMING_RST;
      s_r.tim_attr_r   <= CST_TIMING_RST;
      s_r.tim_io_r     <= CST_TIMING_RST;
      s_r.present_r    <= CST_PRESENCE_RST[CST_PRES_BIT];
      s_r.wait_sy_r    <= 2'h3;
      s_r.io16_sy_r    <= 2'h3;
      s_r.st_r         <= CST_IDLE;
      s_r.strobe_n_r   <= 1'b1;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o            = s_r.dat_r;
  assign wb_ack_o            = s_r.ack_r;
  assign acc_busy_o          = s_r.busy_r;
  assign acc_done_o          = s_r.done_r;
  assign cmd_strobe_n_o      = s_r.strobe_n_r;
  assign io_width16_o        = s_r.io16_r;
  assign card_present_flag_o = s_r.present_r;

endmodule : cst_card_timing

// >>> rtl/cst_pkg.sv
// card slot access timing: constants, register map and carrier types
// assumes a classic wishbone slave with 32-bit data and one clock
package cst_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0]  CST_OFS_COMMON   = 4'h0;
  localparam logic [3:0]  CST_OFS_ATTR     = 4'h4;
  localparam logic [3:0]  CST_OFS_IO       = 4'h8;
  localparam logic [3:0]  CST_OFS_PRESENCE = 4'hC;
  localparam logic [31:0] CST_TIMING_RST   = 32'h0000_0000;
  localparam logic [31:0] CST_PRESENCE_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // timing and presence register fields
  // ------------------------------------------------------------
  localparam int CST_SET_LSB  = 0;
  localparam int CST_SET_W    = 7;
  localparam int CST_ASST_LSB = 7;
  localparam int CST_ASST_W   = 5;
  localparam int CST_HOLD_LSB = 14;
  localparam int CST_HOLD_W   = 6;
  localparam int CST_PRES_BIT = 1;
  localparam logic [31:0] CST_TIMING_MASK = 32'h000F_CFFF;
  localparam logic [31:0] CST_PRES_MASK   = 32'h0000_0002;

  // ------------------------------------------------------------
  // cycle counts
  // ------------------------------------------------------------
  localparam int CST_CNT_W = 8;
  localparam logic [CST_CNT_W-1:0] CST_ONE = 8'h01;
  localparam logic [CST_CNT_W-1:0] CST_TWO = 8'h02;

  // access spaces
  typedef enum logic [1:0] {
    CST_SP_COMMON,
    CST_SP_ATTR,
    CST_SP_IO
  } cst_space_t;

  typedef enum logic [2:0] {
    CST_IDLE,
    CST_SETUP,
    CST_WAITCHK,
    CST_HOLD,
    CST_RECOV
  } cst_state_t;

  // access request from the static controller core
  typedef struct packed {
    logic       req;
    cst_space_t space;
  } cst_acc_t;

  // whole state of the block
  typedef struct packed {
    logic [31:0]          tim_common_r;
    logic [31:0]          tim_attr_r;
    logic [31:0]          tim_io_r;
    logic                 present_r;
    logic                 ack_r;
    logic [31:0]          dat_r;
    logic [1:0]           wait_sy_r;
    logic [1:0]           io16_sy_r;
    logic                 io16_r;
    cst_state_t           st_r;
    logic [CST_CNT_W-1:0] cnt_r;
    logic [CST_CNT_W-1:0] total_r;
    logic [CST_CNT_W-1:0] min_r;
    logic [CST_CNT_W-1:0] hold_r;
    logic                 strobe_n_r;
    logic                 busy_r;
    logic                 done_r;
  } cst_state_s_t;

endpackage : cst_pkg

// >>> verification/cst_card_model.sv
// card in the socket: holds wait low for a set time into each strobe
// assumes the strobe is the controller's registered active low output
`timescale 1ns/1ps
module cst_card_model (
  input  wire logic       clock_i,
  input  wire logic       strobe_n_i,
  input  wire logic [7:0] busy_cyc_i,
  output logic            wait_n_o
);
  logic [7:0] cnt_r;
  always_ff @(posedge clock_i) begin
    if (strobe_n_i) cnt_r <= 8'h00;
    else if (cnt_r != 8'hFF) cnt_r <= cnt_r + 8'h01;
  end
  // pulled up to ready outside a strobe
  assign wait_n_o = strobe_n_i || (cnt_r >= busy_cyc_i);
endmodule : cst_card_model

// >>> verification/cst_checker.sv
// checker: port-level timing relations of the card slot engine
// bound to cst_card_timing by the bench, sees top ports only
`timescale 1ns/1ps
module cst_checker (
  input wire logic clock_i, arst_n_i, clk_en_i, wb_cyc_i, wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic acc_busy_o, acc_done_o, cmd_strobe_n_o,
  input wire logic card_wait_n_i, io_width16_indicate_n_i,
  input wire logic io_width16_o, card_present_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    && clk_en_i |=> wb_ack_o) else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o && clk_en_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  done_pulse_a: assert property (acc_done_o && clk_en_i |=> !acc_done_o)
    else $error("done longer than one cycle");
  busy_end_a: assert property (acc_done_o && clk_en_i |=> !acc_busy_o)
    else $error("busy stays after done");
  strobe_busy_a: assert property (!cmd_strobe_n_o |-> acc_busy_o)
    else $error("strobe outside an access");
  strobe_min_a: assert property ($fell(cmd_strobe_n_o)
    |-> !cmd_strobe_n_o[*3]) else $error("strobe too short");
  wait_hold_a: assert property ($rose(card_wait_n_i)
    && card_present_flag_o && !cmd_strobe_n_o |-> !cmd_strobe_n_o[*4])
    else $error("strobe released early after wait");
  io16_gate_a: assert property (!card_present_flag_o[*2]
    |-> !io_width16_o) else $error("io16 seen without card");
  io16_follow_a: assert property ((card_present_flag_o
    && !io_width16_indicate_n_i)[*5] |-> io_width16_o)
    else $error("io16 not followed");
endmodule : cst_checker

// >>> verification/tb_card_slot_access_timing.sv
// bench: registers, assertion codes, wait handling, setup and hold
// assumes cst_card_model on the card pins, lanes tied on, enable driven by the bench
`timescale 1ns/1ps
module tb_card_slot_access_timing;
  import cst_pkg::*;
  logic clock_i = 1'b0, arst_n_i = 1'b0, cyc = 1'b0, we = 1'b0;
  logic io16_n = 1'b1, ack, busy, done, strb_n, wait_n, io16, pres;
  logic en = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] bsy = 8'h00;
  cst_acc_t acc = '0;
  int failures = 0, n_compared = 0;
  cst_card_timing cst_card_timing_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .clk_en_i(en), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .acc_i(acc), .acc_busy_o(busy),
    .acc_done_o(done), .card_wait_n_i(wait_n),
    .io_width16_indicate_n_i(io16_n), .cmd_strobe_n_o(strb_n),
    .io_width16_o(io16), .card_present_flag_o(pres));
  cst_card_model cst_card_model_i (.clock_i(clock_i), .strobe_n_i(strb_n),
    .busy_cyc_i(bsy), .wait_n_o(wait_n));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, lo, hi);
    n_compared++;
    if (got < lo || got > hi) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clock_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : wb
  task automatic run(input cst_space_t sp, output int lo, su, ho);
    lo = 0;
    su = 0;
    ho = 0;
    acc <= '{1'b1, sp};
    @(posedge clock_i);
    acc.req <= 1'b0;
    while (strb_n !== 1'b0 && su < 400) begin
      @(posedge clock_i);
      su++;
    end
    while (strb_n === 1'b0 && lo < 400) begin
      @(posedge clock_i);
      lo++;
    end
    while (done !== 1'b1 && ho < 400) begin
      @(posedge clock_i);
      ho++;
    end
    @(posedge clock_i);
  endtask : run
  task automatic t_regs;
    logic [31:0] q;
    for (int i = 0; i < 16; i += 4) begin
      wb(1'b0, i[3:0], 32'h0, q);
      chk(q, 32'h0);
    end
    wb(1'b1, CST_OFS_IO, 32'hFFFF_FFFF, q);
    wb(1'b0, CST_OFS_IO, 32'h0, q);
    chk(q, CST_TIMING_MASK);
    wb(1'b1, CST_OFS_PRESENCE, CST_PRES_MASK, q);
    wb(1'b0, CST_OFS_PRESENCE, 32'h0, q);
    chk(q, CST_PRES_MASK);
    chk(pres, 1'b1);
    wb(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    $display("registers finished");
  endtask : t_regs
  task automatic t_codes;
    logic [3:0] ofs[3] = '{CST_OFS_COMMON, CST_OFS_ATTR, CST_OFS_IO};
    int cd[3] = '{0, 5, 31};
    int lo, su, ho;
    logic [31:0] q;
    bsy <= 8'h28;
    wb(1'b1, CST_OFS_PRESENCE, 32'h0, q);
    for (int i = 0; i < 3; i++) wb(1'b1, ofs[i], 32'h4001 | (cd[i] << 7), q);
    for (int i = 0; i < 3; i++) begin
      run(cst_space_t'(i), lo, su, ho);
      chk(lo, 3 * cd[i] + 3);
    end
    $display("codes finished");
  endtask : t_codes
  task automatic t_wait;
    int lo, su, ho;
    logic [31:0] q;
    wb(1'b1, CST_OFS_PRESENCE, CST_PRES_MASK, q);
    wb(1'b1, CST_OFS_ATTR, 32'h4101, q);
    bsy <= 8'h14;
    run(CST_SP_ATTR, lo, su, ho);
    chk_rng(lo, 27, 34);
    bsy <= 8'h00;
    run(CST_SP_ATTR, lo, su, ho);
    chk(lo, 9);
    io16_n <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk(io16, 1'b1);
    wb(1'b1, CST_OFS_PRESENCE, 32'h0, q);
    repeat (3) @(posedge clock_i);
    chk(io16, 1'b0);
    io16_n <= 1'b1;
    $display("wait finished");
  endtask : t_wait
  task automatic t_setup;
    int lo, s0, h0, s1, h1;
    logic [31:0] q;
    wb(1'b1, CST_OFS_COMMON, 32'h0, q);
    run(CST_SP_COMMON, lo, s0, h0);
    wb(1'b1, CST_OFS_COMMON, 32'h4001, q);
    run(CST_SP_COMMON, lo, s1, h1);
    chk(s0, s1);
    chk(h0, h1);
    wb(1'b1, CST_OFS_COMMON, 32'h24005, q);
    run(CST_SP_COMMON, lo, s0, h0);
    chk(s0, s1 + 4);
    chk(h0, h1 + 8);
    $display("setup finished");
  endtask : t_setup
  task automatic t_freeze;
    logic [31:0] q;
    en <= 1'b0;
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= 1'b1;
    adr <= CST_OFS_PRESENCE;
    wdat <= CST_PRES_MASK;
    repeat (4) @(posedge clock_i);
    chk(ack, 1'b0);
    chk(pres, 1'b0);
    en <= 1'b1;
    do @(posedge clock_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    chk(pres, 1'b1);
    wb(1'b1, CST_OFS_PRESENCE, 32'h0, q);
    $display("freeze finished");
  endtask : t_freeze
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial forever #4 clock_i = ~clock_i;
  initial begin
    #200us;
    failures++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs;
    t_codes;
    t_wait;
    t_setup;
    t_freeze;
    wrap_up;
  end
endmodule : tb_card_slot_access_timing
bind cst_card_timing cst_checker cst_checker_i (.clock_i, .arst_n_i, .clk_en_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .acc_busy_o, .acc_done_o,
  .cmd_strobe_n_o, .card_wait_n_i, .io_width16_indicate_n_i,
  .io_width16_o, .card_present_flag_o);
